// ### cbu_pkg.sv
package cbu_pkg;
    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned CBU_PC_W = 12;
    localparam int unsigned CBU_OFS_W = 7;
    localparam int unsigned CBU_OP_W = 4;

    // ------------------------------------------------------------------
    // Operation codes on the op port
    // ------------------------------------------------------------------
    localparam logic [3:0] CBU_OP_BRANCH_IF_NEGATIVE = 4'h0;
    localparam logic [3:0] CBU_OP_BRANCH_IF_POSITIVE = 4'h1;
    localparam logic [3:0] CBU_OP_BRANCH_SIGNED_GE = 4'h2;
    localparam logic [3:0] CBU_OP_BRANCH_SIGNED_LT = 4'h3;
    localparam logic [3:0] CBU_OP_BRANCH_HALFCARRY_SET = 4'h4;
    localparam logic [3:0] CBU_OP_BRANCH_HALFCARRY_CLEAR = 4'h5;
    localparam logic [3:0] CBU_OP_BRANCH_TRANSFER_SET = 4'h6;
    localparam logic [3:0] CBU_OP_BRANCH_TRANSFER_CLEAR = 4'h7;
    localparam logic [3:0] CBU_OP_BRANCH_OVERFLOW_SET = 4'h8;
    localparam logic [3:0] CBU_OP_BRANCH_OVERFLOW_CLEAR = 4'h9;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [11:0] CBU_PC_RST = 12'h000;
    localparam int unsigned CBU_CYC_NOT_TAKEN = 1;
    localparam int unsigned CBU_CYC_TAKEN = 2;

    typedef enum logic [0:0] {
        CBU_IDLE,
        CBU_TAKEN_WAIT
    } cbu_state_e;
endpackage

// ### cbu_cond.sv
`timescale 1ns/1ps
`default_nettype none
module cbu_cond
    import cbu_pkg::*;
(
    input wire logic [cbu_pkg::CBU_OP_W-1:0] op_i,
    input wire logic flag_n_i,
    input wire logic flag_v_i,
    input wire logic flag_h_i,
    input wire logic flag_t_i,
    output logic cond_o,
    output logic legal_o
);
    // Pure flag test; reads the flags only, never writes them
    always_comb begin
        cond_o = 1'b0;
        legal_o = 1'b1;
        case (op_i)
            CBU_OP_BRANCH_IF_NEGATIVE: cond_o = flag_n_i;
            CBU_OP_BRANCH_IF_POSITIVE: cond_o = !flag_n_i;
            CBU_OP_BRANCH_SIGNED_GE: cond_o = !(flag_n_i ^ flag_v_i);
            CBU_OP_BRANCH_SIGNED_LT: cond_o = flag_n_i ^ flag_v_i;
            CBU_OP_BRANCH_HALFCARRY_SET: cond_o = flag_h_i;
            CBU_OP_BRANCH_HALFCARRY_CLEAR: cond_o = !flag_h_i;
            CBU_OP_BRANCH_TRANSFER_SET: cond_o = flag_t_i;
            CBU_OP_BRANCH_TRANSFER_CLEAR: cond_o = !flag_t_i;
            CBU_OP_BRANCH_OVERFLOW_SET: cond_o = flag_v_i;
            CBU_OP_BRANCH_OVERFLOW_CLEAR: cond_o = !flag_v_i;
            default: legal_o = 1'b0; // Unknown codes never branch
        endcase
    end
endmodule
`default_nettype wire

// ### cbu_branch.sv
`timescale 1ns/1ps
`default_nettype none
module cbu_branch #(
    parameter int unsigned PC_W = cbu_pkg::CBU_PC_W,
    parameter int unsigned OFS_W = cbu_pkg::CBU_OFS_W
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic en_i,
    input wire logic issue_i,
    input wire logic [cbu_pkg::CBU_OP_W-1:0] op_i,
    input wire logic [OFS_W-1:0] offset_i,
    input wire logic [PC_W-1:0] pc_i,
    input wire logic [7:0] sreg_i,
    input wire logic flag_n_i,
    input wire logic flag_v_i,
    input wire logic flag_h_i,
    input wire logic flag_t_i,
    output logic busy_o,
    output logic done_o,
    output logic taken_o,
    output logic illegal_o,
    output logic pc_load_o,
    output logic [PC_W-1:0] pc_next_o,
    output logic [7:0] sreg_o
);
    import cbu_pkg::*;

    // ------------------------------------------------------------------
    // Target arithmetic
    // ------------------------------------------------------------------
    // Fall-through address; a taken branch builds on the same base
    function automatic logic [PC_W-1:0] next_seq(input logic [PC_W-1:0] pc);
        next_seq = pc + {{(PC_W-1){1'b0}}, 1'b1};
    endfunction

    // Sign extension is explicit so a short offset can reach backwards
    function automatic logic [PC_W-1:0] target(input logic [PC_W-1:0] pc,
                                               input logic [OFS_W-1:0] k);
        logic [PC_W-1:0] ext;
        ext = {{(PC_W-OFS_W){k[OFS_W-1]}}, k};
        target = next_seq(pc) + ext;
    endfunction

    logic cond;
    logic legal;

    cbu_cond u_cond (
        .op_i(op_i),
        .flag_n_i(flag_n_i),
        .flag_v_i(flag_v_i),
        .flag_h_i(flag_h_i),
        .flag_t_i(flag_t_i),
        .cond_o(cond),
        .legal_o(legal)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    cbu_state_e state_q, state_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic taken_q, taken_d;
    logic illegal_q, illegal_d;
    logic pc_load_q, pc_load_d;
    logic [PC_W-1:0] pc_next_q, pc_next_d;
    logic [7:0] sreg_q, sreg_d;

    // Issue is ignored while busy: the second cycle of a taken branch
    // is a bubble, so the decoder must hold off one cycle
    always_comb begin
        state_d = state_q;
        busy_d = 1'b0;
        done_d = 1'b0;
        taken_d = taken_q;
        illegal_d = 1'b0;
        pc_load_d = 1'b0;
        pc_next_d = pc_next_q;
        sreg_d = sreg_i;
        case (state_q)
            CBU_IDLE: begin
                if (issue_i) begin
                    if (legal && cond) begin
                        state_d = CBU_TAKEN_WAIT;
                        busy_d = 1'b1;
                        taken_d = 1'b1;
                        pc_next_d = target(pc_i, offset_i);
                    end else begin
                        done_d = 1'b1;
                        taken_d = 1'b0;
                        illegal_d = !legal;
                        pc_next_d = next_seq(pc_i);
                    end
                end
            end
            CBU_TAKEN_WAIT: begin
                state_d = CBU_IDLE;
                done_d = 1'b1;
                pc_load_d = 1'b1;
            end
            default: state_d = CBU_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= CBU_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            taken_q <= 1'b0;
            illegal_q <= 1'b0;
            pc_load_q <= 1'b0;
            pc_next_q <= '0;
            sreg_q <= 8'h00;
        end else if (en_i) begin
            state_q <= state_d;
            busy_q <= busy_d;
            done_q <= done_d;
            taken_q <= taken_d;
            illegal_q <= illegal_d;
            pc_load_q <= pc_load_d;
            pc_next_q <= pc_next_d;
            sreg_q <= sreg_d;
        end
    end

    assign busy_o = busy_q;
    assign done_o = done_q;
    assign taken_o = taken_q;
    assign illegal_o = illegal_q;
    assign pc_load_o = pc_load_q;
    assign pc_next_o = pc_next_q;
    assign sreg_o = sreg_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    sequence s_issue_taken;
        en_i && issue_i && state_q == CBU_IDLE && legal && cond;
    endsequence
    // Bubble cycle, then the load strobe; a frozen bubble is not claimed
    sequence s_load_next;
        (busy_o && !done_o) ##1 (pc_load_o && done_o);
    endsequence

    a_neg_taken: assert property (
        (en_i && issue_i && state_q == CBU_IDLE && op_i == CBU_OP_BRANCH_IF_NEGATIVE)
        |=> (busy_o == $past(flag_n_i)))
        else $error("negative branch decision wrong");
    a_pos_taken: assert property (
        (en_i && issue_i && state_q == CBU_IDLE && op_i == CBU_OP_BRANCH_IF_POSITIVE)
        |=> (busy_o == !$past(flag_n_i)))
        else $error("positive branch decision wrong");
    a_ge_taken: assert property (
        (en_i && issue_i && state_q == CBU_IDLE && op_i == CBU_OP_BRANCH_SIGNED_GE)
        |=> (taken_o == !($past(flag_n_i) ^ $past(flag_v_i))))
        else $error("signed ge decision wrong");
    a_lt_taken: assert property (
        (en_i && issue_i && state_q == CBU_IDLE && op_i == CBU_OP_BRANCH_SIGNED_LT)
        |=> (taken_o == ($past(flag_n_i) ^ $past(flag_v_i))))
        else $error("signed lt decision wrong");
    a_hs_taken: assert property (
        (en_i && issue_i && state_q == CBU_IDLE && op_i == CBU_OP_BRANCH_HALFCARRY_SET)
        |=> (taken_o == $past(flag_h_i)))
        else $error("half-carry set decision wrong");
    a_tc_taken: assert property (
        (en_i && issue_i && state_q == CBU_IDLE && op_i == CBU_OP_BRANCH_TRANSFER_CLEAR)
        |=> (taken_o == !$past(flag_t_i)))
        else $error("transfer clear decision wrong");
    a_vs_taken: assert property (
        (en_i && issue_i && state_q == CBU_IDLE && op_i == CBU_OP_BRANCH_OVERFLOW_SET)
        |=> (taken_o == $past(flag_v_i)))
        else $error("overflow set decision wrong");
    a_hc_taken: assert property (
        (en_i && issue_i && state_q == CBU_IDLE && op_i == CBU_OP_BRANCH_HALFCARRY_CLEAR)
        |=> (taken_o == !$past(flag_h_i)))
        else $error("half-carry clear decision wrong");
    a_ts_taken: assert property (
        (en_i && issue_i && state_q == CBU_IDLE && op_i == CBU_OP_BRANCH_TRANSFER_SET)
        |=> (taken_o == $past(flag_t_i)))
        else $error("transfer set decision wrong");
    a_vc_taken: assert property (
        (en_i && issue_i && state_q == CBU_IDLE && op_i == CBU_OP_BRANCH_OVERFLOW_CLEAR)
        |=> (taken_o == !$past(flag_v_i)))
        else $error("overflow clear decision wrong");
    a_taken_target: assert property (
        s_issue_taken |=> (pc_next_o == $past(pc_i) + {{(PC_W-OFS_W){$past(offset_i[OFS_W-1])}},
            $past(offset_i)} + 1'b1))
        else $error("taken target not pc plus offset plus one");
    a_taken_two: assert property (
        s_issue_taken ##1 en_i |-> s_load_next)
        else $error("taken branch not two cycles");
    a_sreg_kept: assert property (
        en_i |=> (sreg_o == $past(sreg_i)))
        else $error("status flags altered");
endmodule
`default_nettype wire

// ### cbu_branch_test.sv
`timescale 1ns/1ps
`default_nettype none
module cbu_branch_test;
    import cbu_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus and bookkeeping
    // ------------------------------------------------------------------
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic en_i = 1'b1;
    logic issue_i = 1'b0;
    logic [3:0] op_i = 4'h0;
    logic [6:0] offset_i = 7'h00;
    logic [11:0] pc_i = 12'h000;
    logic [7:0] sreg_i = 8'h00;
    logic flag_n_i = 1'b0;
    logic flag_v_i = 1'b0;
    logic flag_h_i = 1'b0;
    logic flag_t_i = 1'b0;
    logic busy_o, done_o, taken_o, illegal_o, pc_load_o;
    logic [11:0] pc_next_o;
    logic [7:0] sreg_o;
    int n_fail = 0;
    int checks_done = 0;

    cbu_branch dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .en_i(en_i), .issue_i(issue_i),
        .op_i(op_i), .offset_i(offset_i), .pc_i(pc_i), .sreg_i(sreg_i),
        .flag_n_i(flag_n_i), .flag_v_i(flag_v_i), .flag_h_i(flag_h_i), .flag_t_i(flag_t_i),
        .busy_o(busy_o), .done_o(done_o), .taken_o(taken_o), .illegal_o(illegal_o),
        .pc_load_o(pc_load_o), .pc_next_o(pc_next_o), .sreg_o(sreg_o));

    // 100 MHz core clock
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Four-state compare so an unknown output never counts as a match
    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Flags packed as {n, v, h, t}; unknown codes never branch
    function automatic logic exp_take(input logic [3:0] op, input logic [3:0] f);
        case (op)
            CBU_OP_BRANCH_IF_NEGATIVE: return f[3];
            CBU_OP_BRANCH_IF_POSITIVE: return !f[3];
            CBU_OP_BRANCH_SIGNED_GE: return !(f[3] ^ f[2]);
            CBU_OP_BRANCH_SIGNED_LT: return f[3] ^ f[2];
            CBU_OP_BRANCH_HALFCARRY_SET: return f[1];
            CBU_OP_BRANCH_HALFCARRY_CLEAR: return !f[1];
            CBU_OP_BRANCH_TRANSFER_SET: return f[0];
            CBU_OP_BRANCH_TRANSFER_CLEAR: return !f[0];
            CBU_OP_BRANCH_OVERFLOW_SET: return f[2];
            CBU_OP_BRANCH_OVERFLOW_CLEAR: return !f[2];
            default: return 1'b0;
        endcase
    endfunction

    // One branch; during a bubble the request is held with a changed PC, which must be ignored
    task automatic br(input logic [3:0] op, input logic [3:0] f, input logic [11:0] pc,
                      input logic [6:0] k);
        logic tk;
        logic [11:0] tgt;
        tk = exp_take(op, f);
        tgt = tk ? pc + {{5{k[6]}}, k} + 12'h001 : pc + 12'h001;
        @(posedge clk_sys_i);
        issue_i <= 1'b1;
        op_i <= op;
        {flag_n_i, flag_v_i, flag_h_i, flag_t_i} <= f;
        pc_i <= pc;
        offset_i <= k;
        sreg_i <= {f, op};
        @(posedge clk_sys_i);
        issue_i <= tk;
        pc_i <= ~pc;
        #1;
        chk("taken", taken_o, tk);
        chk("pc_next", pc_next_o, tgt);
        chk("sreg", sreg_o, {f, op});
        chk("busy", busy_o, tk);
        chk("done", done_o, !tk);
        chk("illegal", illegal_o, op > CBU_OP_BRANCH_OVERFLOW_CLEAR);
        chk("pc_load", pc_load_o, 1'b0);
        if (tk) begin
            @(posedge clk_sys_i);
            issue_i <= 1'b0;
            #1;
            chk("done2", done_o, 1'b1);
            chk("pc_load2", pc_load_o, 1'b1);
            chk("busy2", busy_o, 1'b0);
            chk("pc_next2", pc_next_o, tgt);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        #1;
        chk("reset done", done_o, 1'b0);
        chk("reset pc_next", pc_next_o, 12'h000);
        // Codes 0 to 10 against every flag pattern, offsets across the signed range
        for (int op = 0; op < 11; op++) begin
            for (int f = 0; f < 16; f++) begin
                br(op[3:0], f[3:0], 12'h100 + 12'(op * 16 + f), 7'(f * 9 + op * 13));
            end
        end
        $display("test codes_and_flags done");
        // Offset extremes and PC wrap
        br(4'h0, 4'h8, 12'hfff, 7'h3f);
        br(4'h0, 4'h8, 12'h000, 7'h40);
        br(4'hf, 4'hf, 12'h123, 7'h7f);
        $display("test offset_bounds done");
        // Clock enable low freezes a pending request
        @(posedge clk_sys_i);
        en_i <= 1'b0;
        issue_i <= 1'b1;
        op_i <= 4'h0;
        flag_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk("frozen busy", busy_o, 1'b0);
        chk("frozen done", done_o, 1'b0);
        @(posedge clk_sys_i);
        issue_i <= 1'b0;
        en_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        $display("test enable_freeze done");
        summarize();
    end
endmodule
`default_nettype wire
